// ---- shared/asd_consts.svh ----
// constants of the record service decoder: record indices, parameters, layouts, status
// assumes inclusion by bare name from package and design files
`ifndef ASD_CONSTS_SVH
`define ASD_CONSTS_SVH

// ----------------------------------------------------------------
// record indices and request parameters
// ----------------------------------------------------------------
`define ASD_REC_AOUT 8'h1A
`define ASD_REC_DELTA 8'h40
`define ASD_REC_CORRUPT 8'h41
`define ASD_PARAM_ONE 8'h01
`define ASD_SLOT_SEG0 8'h00
`define ASD_SLOT_SEG1 8'h64

// ----------------------------------------------------------------
// status byte values
// ----------------------------------------------------------------
`define ASD_ST_OK 8'h00
`define ASD_ST_NOK 8'h01

// ----------------------------------------------------------------
// analog output image frame layout
// ----------------------------------------------------------------
`define ASD_AOUT_FIRST 8'h02
`define ASD_AOUT_LAST 8'hF9
`define ASD_AOUT_END 8'hFB
`define ASD_AOUT_NODE_BYTES 8'h08

// ----------------------------------------------------------------
// list and write response layout
// ----------------------------------------------------------------
`define ASD_LIST_FIRST 4'h2
`define ASD_LIST_B_FIRST 4'h6
`define ASD_LIST_LASTMAP 4'h9
`define ASD_LIST_STAT 4'hB
`define ASD_LIST_LEN 8'h0C
`define ASD_WR_RSP_LEN 8'h01

`endif

// ---- shared/asd_pkg.sv ----
// types shared by both ends of the record service link
// assumes asd_consts.svh on the include path
`default_nettype none
package asd_pkg;
  `include "asd_consts.svh"

  // ----------------------------------------------------------------
  // services and state machines
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ASD_SVC_AOUT = 2'h0,
    ASD_SVC_DELTA = 2'h1,
    ASD_SVC_CORRUPT = 2'h2
  } asd_service_t;

  typedef enum logic [2:0] {
    ASD_D_IDLE = 3'b001,
    ASD_D_WDATA = 3'b010,
    ASD_D_RESP = 3'b100
  } asd_dev_state_t;

  typedef enum logic [2:0] {
    ASD_H_IDLE = 3'b001,
    ASD_H_SEND = 3'b010,
    ASD_H_WAIT = 3'b100
  } asd_host_state_t;

  // ----------------------------------------------------------------
  // register state of each end
  // ----------------------------------------------------------------
  typedef struct packed {
    asd_dev_state_t st;
    logic seg;
    asd_service_t svc;
    logic ok;
    logic [7:0] cnt;
    logic [7:0] len;
    logic [63:0] snap;
    logic d2h_valid;
    logic [7:0] d2h_data;
    logic d2h_last;
    logic [15:0] rd_data;
    logic upd;
    logic upd_seg;
    logic rej;
  } asd_dev_reg_t;

  typedef struct packed {
    asd_host_state_t st;
    asd_service_t svc;
    logic [7:0] addr;
    logic [3:0] rx;
    logic h2d_start;
    logic h2d_write;
    logic [7:0] h2d_rec_index;
    logic [7:0] h2d_param_index;
    logic [7:0] h2d_slot;
    logic [7:0] h2d_subslot;
    logic h2d_valid;
    logic [7:0] h2d_data;
    logic h2d_last;
    logic busy;
    logic done;
    logic [7:0] status;
    logic [63:0] list;
  } asd_host_reg_t;
endpackage : asd_pkg
`default_nettype wire

// ---- shared/asd_link_if.sv ----
// link between controller end and gateway end: request header, byte stream, response stream
// assumes both ends on the same clock
`default_nettype none
interface asd_link_if;
  logic h2d_start;
  logic h2d_write;
  logic [7:0] h2d_rec_index;
  logic [7:0] h2d_param_index;
  logic [7:0] h2d_slot;
  logic [7:0] h2d_subslot;
  logic h2d_valid;
  logic [7:0] h2d_data;
  logic h2d_last;
  logic d2h_valid;
  logic [7:0] d2h_data;
  logic d2h_last;

  modport dev (
    input h2d_start, h2d_write, h2d_rec_index, h2d_param_index, h2d_slot, h2d_subslot,
    input h2d_valid, h2d_data, h2d_last,
    output d2h_valid, d2h_data, d2h_last
  );
  modport host (
    output h2d_start, h2d_write, h2d_rec_index, h2d_param_index, h2d_slot, h2d_subslot,
    output h2d_valid, h2d_data, h2d_last,
    input d2h_valid, d2h_data, d2h_last
  );
endinterface : asd_link_if
`default_nettype wire

// ---- src/asd_host_end.sv ----
// controller end: issues record requests, streams image bytes, collects responses
// assumes user logic on clk_sys returns src_data for src_addr in the same cycle
`include "asd_consts.svh"
`default_nettype none
module asd_host_end
  import asd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  asd_link_if.host link,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_service,
  input wire logic [7:0] cmd_slot,
  input wire logic [7:0] cmd_param_index,
  input wire logic [7:0] cmd_subslot,
  input wire logic [7:0] src_data,
  output logic [7:0] src_addr,
  output logic cmd_busy,
  output logic done,
  output logic [7:0] done_status,
  output logic [63:0] done_list
);

  asd_host_reg_t r;
  asd_host_reg_t next_r;

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.h2d_start = 1'b0;
    next_r.h2d_valid = 1'b0;
    next_r.h2d_last = 1'b0;
    next_r.h2d_data = 8'h00;
    next_r.done = 1'b0;
    case (r.st)
      ASD_H_IDLE: begin
        if (cmd_valid) begin
          next_r.svc = asd_service_t'(cmd_service);
          next_r.h2d_start = 1'b1;
          next_r.h2d_param_index = cmd_param_index;
          next_r.h2d_subslot = cmd_subslot;
          next_r.h2d_slot = cmd_slot;
          next_r.busy = 1'b1;
          next_r.addr = 8'h00;
          next_r.rx = 4'h0;
          next_r.list = 64'h0000_0000_0000_0000;
          next_r.status = `ASD_ST_NOK;
          case (asd_service_t'(cmd_service))
            ASD_SVC_DELTA: begin
              next_r.h2d_write = 1'b0;
              next_r.h2d_rec_index = `ASD_REC_DELTA;
              next_r.st = ASD_H_WAIT;
            end
            ASD_SVC_CORRUPT: begin
              next_r.h2d_write = 1'b0;
              next_r.h2d_rec_index = `ASD_REC_CORRUPT;
              next_r.st = ASD_H_WAIT;
            end
            default: begin
              next_r.h2d_write = 1'b1;
              next_r.h2d_rec_index = `ASD_REC_AOUT;
              next_r.st = ASD_H_SEND;
            end
          endcase
        end
      end
      ASD_H_SEND: begin
        // bytes outside the channel area go out as zero
        next_r.h2d_valid = 1'b1;
        if (r.addr >= `ASD_AOUT_FIRST && r.addr <= `ASD_AOUT_LAST) begin
          next_r.h2d_data = src_data;
        end
        next_r.addr = r.addr + 8'h01;
        if (r.addr == `ASD_AOUT_END) begin
          next_r.h2d_last = 1'b1;
          next_r.st = ASD_H_WAIT;
        end
      end
      ASD_H_WAIT: begin
        if (link.d2h_valid) begin
          next_r.rx = r.rx + 4'h1;
          if (r.svc == ASD_SVC_AOUT) begin
            next_r.status = link.d2h_data;
          end else if (r.rx == `ASD_LIST_STAT) begin
            next_r.status = link.d2h_data;
          end else if (r.rx >= `ASD_LIST_FIRST && r.rx <= `ASD_LIST_LASTMAP) begin
            next_r.list[{r.rx[2:0] - 3'h2, 3'h0} +: 8] = link.d2h_data;
          end
          if (link.d2h_last) begin
            next_r.done = 1'b1;
            next_r.busy = 1'b0;
            next_r.st = ASD_H_IDLE;
          end
        end
      end
      default: begin
        next_r.st = ASD_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.st <= ASD_H_IDLE;
      r.status <= `ASD_ST_OK;
    end else begin
      r <= next_r;
    end
  end

  assign link.h2d_start = r.h2d_start;
  assign link.h2d_write = r.h2d_write;
  assign link.h2d_rec_index = r.h2d_rec_index;
  assign link.h2d_param_index = r.h2d_param_index;
  assign link.h2d_slot = r.h2d_slot;
  assign link.h2d_subslot = r.h2d_subslot;
  assign link.h2d_valid = r.h2d_valid;
  assign link.h2d_data = r.h2d_data;
  assign link.h2d_last = r.h2d_last;
  assign src_addr = r.addr;
  assign cmd_busy = r.busy;
  assign done = r.done;
  assign done_status = r.status;
  assign done_list = r.list;

endmodule : asd_host_end
`default_nettype wire

// ---- src/asd_device_end.sv ----
// gateway end: decodes record requests, holds both analog output images, answers lists
// assumes the controller end on clk_sys and one request outstanding at a time
//
// Summary of operation
// - record 0x1A write updates analog output image
// - requests carry index 0x01 and subslot 0x01
// - slot 0 is segment one, 100 segment two
// - controller addresses subslot 1 before requests
// - bytes 6,7: channel 2 or B channel 0
// - bytes 8,9: channel 3 or B channel 1
// - eight bytes per node, node 31 at 242-249
// - every image write answered with status byte
// - status is OK or NOK only
// - record 0x40 read returns delta list
// - record 0x41 read returns corrupted node list
// - corrupted list has one bit per node
// - bytes 0,1 zero; byte 2 nodes 7..1
// - B nodes from byte 6; byte 9 31B..24B
// - byte 10 unused, status in byte 11
`include "asd_consts.svh"
`default_nettype none
module asd_device_end
  import asd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  asd_link_if.dev link,
  input wire logic [63:0] delta_list_seg0,
  input wire logic [63:0] delta_list_seg1,
  input wire logic [63:0] corrupted_node_list_seg0,
  input wire logic [63:0] corrupted_node_list_seg1,
  input wire logic aout_rd_seg,
  input wire logic [4:0] aout_rd_node,
  input wire logic [1:0] aout_rd_chan,
  output logic [15:0] aout_rd_data,
  output logic aout_update,
  output logic aout_update_seg,
  output logic req_reject
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic param_ok(input logic [7:0] idx, input logic [7:0] sub, input logic [7:0] slot);
    param_ok = (idx == `ASD_PARAM_ONE) && (sub == `ASD_PARAM_ONE)
      && ((slot == `ASD_SLOT_SEG0) || (slot == `ASD_SLOT_SEG1));
  endfunction : param_ok

  // byte offset of channel ch of node n; channels 2,3 alias B channels 0,1
  function automatic logic [7:0] aout_addr(input logic [4:0] node, input logic [1:0] ch);
    logic [7:0] base;
    base = {node, 3'h0} - `ASD_AOUT_NODE_BYTES + `ASD_AOUT_FIRST;
    aout_addr = base + {5'h00, ch, 1'b0};
  endfunction : aout_addr

  // list byte k: bit n of the map is node n (A or single), bit 32+n node nB
  function automatic logic [7:0] list_byte(input logic [63:0] map, input logic [3:0] k);
    logic [7:0] b;
    b = 8'h00;
    if (k >= `ASD_LIST_FIRST && k <= `ASD_LIST_LASTMAP) begin
      b = map[{k[2:0] - 3'h2, 3'h0} +: 8];
      if (k == `ASD_LIST_FIRST || k == `ASD_LIST_B_FIRST) begin
        b[0] = 1'b0;
      end
    end
    list_byte = b;
  endfunction : list_byte

  // ----------------------------------------------------------------
  // image storage
  // ----------------------------------------------------------------
  // one 256-byte page per segment; only 2..249 are ever written
  logic [7:0] img [0:511];
  logic mem_we;
  logic [8:0] mem_waddr;
  logic [7:0] rd_lo;
  logic [8:0] rd_a0;
  logic [8:0] rd_a1;

  asd_dev_reg_t r;
  asd_dev_reg_t next_r;

  logic start_ok;
  logic start_seg;
  logic [7:0] rsp_byte;

  always_comb begin
    start_ok = param_ok(link.h2d_param_index, link.h2d_subslot, link.h2d_slot);
    start_seg = (link.h2d_slot == `ASD_SLOT_SEG1);
    rd_lo = aout_addr(aout_rd_node, aout_rd_chan);
    rd_a0 = {aout_rd_seg, rd_lo};
    rd_a1 = {aout_rd_seg, rd_lo + 8'h01};
  end

  // ----------------------------------------------------------------
  // response byte selection
  // ----------------------------------------------------------------
  always_comb begin
    rsp_byte = 8'h00;
    if (r.svc == ASD_SVC_AOUT) begin
      rsp_byte = r.ok ? `ASD_ST_OK : `ASD_ST_NOK;
    end else if (r.cnt[3:0] == `ASD_LIST_STAT) begin
      rsp_byte = r.ok ? `ASD_ST_OK : `ASD_ST_NOK;
    end else begin
      // byte 10 and anything past the map fall through as zero
      rsp_byte = list_byte(r.snap, r.cnt[3:0]);
    end
  end

  // ----------------------------------------------------------------
  // request sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.d2h_valid = 1'b0;
    next_r.d2h_last = 1'b0;
    next_r.d2h_data = 8'h00;
    next_r.upd = 1'b0;
    next_r.rej = 1'b0;
    mem_we = 1'b0;
    mem_waddr = {r.seg, r.cnt};
    next_r.rd_data = (aout_rd_node == 5'h00) ? 16'h0000 : {img[rd_a0], img[rd_a1]};
    case (r.st)
      ASD_D_IDLE: begin
        if (link.h2d_start) begin
          next_r.seg = start_seg;
          next_r.cnt = 8'h00;
          next_r.snap = 64'h0000_0000_0000_0000;
          if (link.h2d_write) begin
            next_r.svc = ASD_SVC_AOUT;
            next_r.ok = start_ok && (link.h2d_rec_index == `ASD_REC_AOUT);
            next_r.len = `ASD_WR_RSP_LEN;
            next_r.st = ASD_D_WDATA;
          end else begin
            next_r.len = `ASD_LIST_LEN;
            next_r.st = ASD_D_RESP;
            next_r.ok = 1'b0;
            next_r.svc = ASD_SVC_DELTA;
            if (start_ok && link.h2d_rec_index == `ASD_REC_DELTA) begin
              next_r.ok = 1'b1;
              next_r.snap = start_seg ? delta_list_seg1 : delta_list_seg0;
            end else if (start_ok && link.h2d_rec_index == `ASD_REC_CORRUPT) begin
              next_r.ok = 1'b1;
              next_r.svc = ASD_SVC_CORRUPT;
              next_r.snap = start_seg ? corrupted_node_list_seg1 : corrupted_node_list_seg0;
            end
            next_r.rej = !next_r.ok;
          end
        end
      end
      ASD_D_WDATA: begin
        if (link.h2d_valid) begin
          // a frame refused at the header is drained but leaves the image untouched
          if (r.ok && r.cnt >= `ASD_AOUT_FIRST && r.cnt <= `ASD_AOUT_LAST) begin
            mem_we = 1'b1;
          end
          if (r.cnt != 8'hFF) begin
            next_r.cnt = r.cnt + 8'h01;
          end
          if (link.h2d_last) begin
            // short or long frames count as not written
            next_r.ok = r.ok && (r.cnt == `ASD_AOUT_END);
            next_r.upd = next_r.ok;
            next_r.upd_seg = r.seg;
            next_r.rej = !next_r.ok;
            next_r.cnt = 8'h00;
            next_r.st = ASD_D_RESP;
          end
        end
      end
      ASD_D_RESP: begin
        next_r.d2h_valid = 1'b1;
        next_r.d2h_data = rsp_byte;
        next_r.cnt = r.cnt + 8'h01;
        if (r.cnt == r.len - 8'h01) begin
          next_r.d2h_last = 1'b1;
          next_r.st = ASD_D_IDLE;
        end
      end
      default: begin
        next_r.st = ASD_D_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.st <= ASD_D_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // image cleared at reset so reads before the first write are defined
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 512; i++) begin
        img[i] <= 8'h00;
      end
    end else if (mem_we) begin
      img[mem_waddr] <= link.h2d_data;
    end
  end

  assign link.d2h_valid = r.d2h_valid;
  assign link.d2h_data = r.d2h_data;
  assign link.d2h_last = r.d2h_last;
  assign aout_rd_data = r.rd_data;
  assign aout_update = r.upd;
  assign aout_update_seg = r.upd_seg;
  assign req_reject = r.rej;

endmodule : asd_device_end
`default_nettype wire

// ---- sim/asd_link_assertions.sv ----
// link checker: request framing and response layout seen on the wires
// assumes one clock for both ends and one request outstanding
`include "asd_consts.svh"
`default_nettype none
module asd_link_assertions (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic h2d_start,
  input wire logic h2d_write,
  input wire logic [7:0] h2d_rec_index,
  input wire logic [7:0] h2d_param_index,
  input wire logic [7:0] h2d_slot,
  input wire logic [7:0] h2d_subslot,
  input wire logic h2d_valid,
  input wire logic h2d_last,
  input wire logic d2h_valid,
  input wire logic [7:0] d2h_data,
  input wire logic d2h_last
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // request classification
  // ----------------------------------------------------------------
  logic bad;
  logic bad_q;
  logic rd_go;
  assign bad = h2d_param_index != `ASD_PARAM_ONE || h2d_subslot != `ASD_PARAM_ONE
    || !(h2d_slot inside {`ASD_SLOT_SEG0, `ASD_SLOT_SEG1})
    || (h2d_write ? h2d_rec_index != `ASD_REC_AOUT : !(h2d_rec_index inside {`ASD_REC_DELTA, `ASD_REC_CORRUPT}));
  assign rd_go = h2d_start && !h2d_write;
  // header only valid with start, so keep the verdict for the write answer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bad_q <= 1'b0;
    end else if (h2d_start) begin
      bad_q <= bad;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_start_pulse: assert property (h2d_start |=> !h2d_start) else $error("start longer than one cycle");
  a_list_twelve: assert property (rd_go |-> ##2 (d2h_valid && !d2h_last) [*8] ##1 (d2h_valid && !d2h_last) [*3]
    ##1 (d2h_valid && d2h_last)) else $error("list response length wrong");
  a_list_head: assert property (rd_go |-> ##2 d2h_data == 8'h00 ##1 d2h_data == 8'h00)
    else $error("list head not zero");
  a_unused_bits: assert property (rd_go |-> ##4 !d2h_data[0] ##4 !d2h_data[0])
    else $error("unused list bit set");
  a_byte_ten: assert property (rd_go |-> ##12 d2h_data == 8'h00) else $error("list byte ten not zero");
  a_bad_list_nok: assert property (rd_go && bad |-> ##13 d2h_data == `ASD_ST_NOK) else $error("bad read not refused");
  a_bad_list_blank: assert property (rd_go && bad |-> ##4 (d2h_data == 8'h00) [*8])
    else $error("refused list carries map");
  a_write_answer: assert property (h2d_valid && h2d_last && h2d_write |-> ##2 d2h_valid && d2h_last)
    else $error("write not answered");
  a_write_status: assert property (h2d_valid && h2d_last && h2d_write
    |-> ##2 d2h_data == (bad_q ? `ASD_ST_NOK : `ASD_ST_OK)) else $error("write status wrong");
  a_status_pair: assert property (d2h_valid && d2h_last |-> d2h_data inside {`ASD_ST_OK, `ASD_ST_NOK})
    else $error("status outside two values");
endmodule : asd_link_assertions
`default_nettype wire

// ---- sim/asi_record_service_decoder_test.sv ----
// bench: both ends joined by the link, image writes and list reads checked at user ports
// assumes asd_pkg, asd_link_if and both ends compiled before
`include "asd_consts.svh"
`default_nettype none
module asi_record_service_decoder_test
  import asd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // stimulus and models
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_service = 2'h0;
  logic [7:0] cmd_slot = 8'h00, cmd_param_index = 8'h00, cmd_subslot = 8'h00;
  logic [7:0] src_data, src_addr, done_status;
  logic cmd_busy, done, aout_update, aout_update_seg, req_reject;
  logic [63:0] done_list;
  logic [63:0] lists [4] = '{default: 64'h0};
  logic aout_rd_seg = 1'b0;
  logic [4:0] aout_rd_node = 5'h00;
  logic [1:0] aout_rd_chan = 2'h0;
  logic [15:0] aout_rd_data;
  logic [7:0] img [252] = '{default: 8'h00};
  logic [7:0] shadow [2][252] = '{default: '{default: 8'h00}};
  int fail_count = 0, n_tests = 0, n_upd = 0, n_rej = 0;

  asd_link_if link ();
  assign src_data = img[src_addr];
  always #2 clk_sys = ~clk_sys;
  // counted mid-cycle so the pulse is settled when read
  always @(negedge clk_sys) begin
    n_upd += aout_update;
    n_rej += req_reject;
  end

  asd_host_end i_asd_host_end (.clk_sys, .rstn, .link(link), .cmd_valid, .cmd_service, .cmd_slot,
    .cmd_param_index, .cmd_subslot, .src_data, .src_addr, .cmd_busy, .done, .done_status, .done_list);
  asd_device_end i_asd_device_end (.clk_sys, .rstn, .link(link), .delta_list_seg0(lists[0]),
    .delta_list_seg1(lists[1]), .corrupted_node_list_seg0(lists[2]), .corrupted_node_list_seg1(lists[3]),
    .aout_rd_seg, .aout_rd_node, .aout_rd_chan, .aout_rd_data, .aout_update, .aout_update_seg, .req_reject);
  asd_link_assertions i_asd_link_assertions (.clk_sys, .rstn, .h2d_start(link.h2d_start),
    .h2d_write(link.h2d_write), .h2d_rec_index(link.h2d_rec_index), .h2d_param_index(link.h2d_param_index),
    .h2d_slot(link.h2d_slot), .h2d_subslot(link.h2d_subslot), .h2d_valid(link.h2d_valid),
    .h2d_last(link.h2d_last), .d2h_valid(link.d2h_valid), .d2h_data(link.d2h_data), .d2h_last(link.d2h_last));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic req(input logic [1:0] svc, input logic [7:0] slot, input logic [7:0] pi, input logic [7:0] sub);
    for (int i = 0; i < 10 && cmd_busy !== 1'b0; i++) @(posedge clk_sys) #1;
    cmd_service = svc;
    cmd_slot = slot;
    cmd_param_index = pi;
    cmd_subslot = sub;
    cmd_valid = 1'b1;
    @(posedge clk_sys) #1;
    cmd_valid = 1'b0;
    chk(cmd_busy, 1'b1, "busy");
    for (int i = 0; i < 400 && done !== 1'b1; i++) @(posedge clk_sys) #1;
    chk(done, 1'b1, "done");
    chk(cmd_busy, 1'b0, "idle");
  endtask : req

  task automatic rd(input logic seg, input logic [4:0] node);
    int a;
    for (int c = 0; c < 4; c++) begin
      a = 2 + 8 * (node - 1) + 2 * c;
      aout_rd_seg = seg;
      aout_rd_node = node;
      aout_rd_chan = 2'(c);
      @(posedge clk_sys) #1;
      chk(aout_rd_data, {shadow[seg][a], shadow[seg][a + 1]}, "image");
    end
  endtask : rd

  // random image body; node 1 and node 31 always looked at
  task automatic wr(input logic seg, input logic [7:0] slot, input logic [7:0] pi, input logic [7:0] sub, input bit good);
    for (int k = 2; k < 250; k++) img[k] = 8'($urandom);
    req(ASD_SVC_AOUT, slot, pi, sub);
    chk(done_status, good ? `ASD_ST_OK : `ASD_ST_NOK, "write status");
    if (good) begin
      shadow[seg] = img;
      chk(aout_update_seg, seg, "segment");
    end
    for (int j = 0; j < 6; j++) rd(seg, j == 0 ? 5'd1 : j == 1 ? 5'd31 : 5'($urandom_range(31, 1)));
  endtask : wr

  task automatic lst(input logic [1:0] svc, input logic seg, input logic [7:0] slot, input logic [7:0] pi, input bit good);
    logic [63:0] exp;
    exp = good ? lists[{svc == ASD_SVC_CORRUPT, seg}] & ~64'h0000_0001_0000_0001 : 64'h0;
    req(svc, slot, pi, 8'h01);
    chk(done_list, exp, "list");
    chk(done_status, good ? `ASD_ST_OK : `ASD_ST_NOK, "list status");
  endtask : lst

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hd594));
    repeat (5) @(posedge clk_sys);
    #1 rstn = 1'b1;
    for (int r = 0; r < 2; r++) begin
      foreach (lists[i]) lists[i] = {$urandom, $urandom};
      wr(1'b0, 8'h00, 8'h01, 8'h01, 1'b1);
      wr(1'b1, 8'h64, 8'h01, 8'h01, 1'b1);
      for (int s = 1; s < 3; s++) begin
        lst(2'(s), 1'b0, 8'h00, 8'h01, 1'b1);
        lst(2'(s), 1'b1, 8'h64, 8'h01, 1'b1);
      end
    end
    // refused writes must leave the stored image as it was
    wr(1'b0, 8'h05, 8'h01, 8'h01, 1'b0);
    wr(1'b0, 8'h00, 8'h02, 8'h01, 1'b0);
    wr(1'b1, 8'h64, 8'h01, 8'h00, 1'b0);
    lst(2'h1, 1'b0, 8'h63, 8'h01, 1'b0);
    lst(2'h2, 1'b1, 8'h64, 8'h00, 1'b0);
    chk(n_upd, 4, "updates");
    chk(n_rej, 5, "rejects");
    wrap_up;
  end

  initial begin
    #100000;
    fail_count++;
    wrap_up;
  end
endmodule : asi_record_service_decoder_test
`default_nettype wire
